// [rtl/rlps_pkg.sv]
package rlps_pkg;

  // ****************************************
  // Channels and gearbox
  // ****************************************
  localparam int N_CH       = 4;
  localparam int GB_WIDTH   = 64;
  localparam int TX_SHIFT_W = 7;
  localparam int RX_SLIP_W  = 6;
  localparam logic [TX_SHIFT_W-1:0] TX_SHIFT_MAX = 7'h3f;

  // ****************************************
  // Block lock
  // ****************************************
  localparam logic [6:0] LOCK_GOOD_LAST  = 7'h3f;
  localparam logic [4:0] UNLOCK_BAD_LAST = 5'h0f;
  localparam logic [5:0] MON_WIN_LAST    = 6'h3f;
  localparam logic [1:0] SH_STRETCH      = 2'h3;

  // ****************************************
  // Error ratio monitor and counters
  // ****************************************
  localparam int CLK_PERIOD_NS     = 4;
  localparam int BER_WINDOW_NS     = 125000;
  localparam int BER_WINDOW_CYCLES = BER_WINDOW_NS / CLK_PERIOD_NS;
  localparam int BER_HOLD_CYCLES   = (BER_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BER_TMR_W         = 15;
  localparam logic [4:0] HIGH_BER_BAD = 5'h10;
  localparam int ERRBLK_W          = 8;
  localparam int BERCNT_W          = 6;

  // ****************************************
  // Pattern verifier
  // ****************************************
  localparam int PRBS_W = 8;
  localparam logic [4:0] PRBS_PASS_LAST = 5'h0f;

  // ****************************************
  // Register port
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LIVE       = 8'h08;
  localparam int EV_W           = 12;
  localparam int EV_LOCKLOSS    = 0;
  localparam int EV_HIGHBER     = 4;
  localparam int EV_PRBSERR     = 8;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 12'h000;

  typedef enum logic {LK_HUNT, LK_LOCKED} rlps_lock_e;

  // Next word of x^7+x^6+1, oldest bit in the msb
  function automatic logic [PRBS_W-1:0] rlps_prbs_next(input logic [6:0] seed);
    logic [6:0] st;
    logic [PRBS_W-1:0] w;
    st = seed;
    w  = '0;
    for (int i = PRBS_W - 1; i >= 0; i--) begin
      w[i] = st[6] ^ st[5];
      st   = {st[5:0], w[i]};
    end
    return w;
  endfunction : rlps_prbs_next

endpackage : rlps_pkg

// [rtl/rlps_stretch.sv]
`timescale 1ns/1ns
module rlps_stretch #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // One-cycle events in, stretched levels out
  input  wire logic [W-1:0] ev,
  output logic      [W-1:0] stretched
);
  import rlps_pkg::*;

  logic [1:0] cnt [W];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < W; i++) begin
        cnt[i]       <= 2'h0;
        stretched[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ev[i]) begin
          cnt[i] <= SH_STRETCH;
        end else if (cnt[i] != 2'h0) begin
          cnt[i] <= cnt[i] - 2'h1;
        end
        stretched[i] <= ev[i] | (cnt[i] > 2'h1);
      end
    end
  end

endmodule : rlps_stretch

// [rtl/rlps_top.sv]
`timescale 1ns/1ns
module rlps_top #(
  parameter int BER_WIN_CYC  = rlps_pkg::BER_WINDOW_CYCLES,
  parameter int BER_HOLD_CYC = rlps_pkg::BER_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                                        core_clk,
  input  wire logic                                        rst_b,
  // Register port
  input  wire logic [rlps_pkg::ADDR_W-1:0]                 reg_addr,
  input  wire logic [rlps_pkg::DATA_W-1:0]                 reg_wdata,
  input  wire logic                                        reg_wr,
  input  wire logic                                        reg_rd,
  output logic      [rlps_pkg::DATA_W-1:0]                 reg_rdata,
  output logic                                             irq,
  // Block synchronizer
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_hdr_valid,
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_hdr_bad,
  output logic      [rlps_pkg::N_CH-1:0]                   rx_block_locked,
  output logic      [rlps_pkg::N_CH-1:0]                   rx_bad_sync_header,
  // Metaframe control words
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_skip_slot,
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_diag_slot,
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_ctl_word_ok,
  input  wire logic [2*rlps_pkg::N_CH-1:0]                 rx_diag_lane_bits,
  output logic      [rlps_pkg::N_CH-1:0]                   rx_skip_word_error,
  output logic      [rlps_pkg::N_CH-1:0]                   rx_diag_word_error,
  output logic      [2*rlps_pkg::N_CH-1:0]                 rx_lane_status_msg,
  // Gearbox slip
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_gearbox_slip,
  output logic      [rlps_pkg::RX_SLIP_W*rlps_pkg::N_CH-1:0] rx_slip_offset,
  input  wire logic [rlps_pkg::TX_SHIFT_W*rlps_pkg::N_CH-1:0] tx_gearbox_shift,
  output logic      [rlps_pkg::TX_SHIFT_W*rlps_pkg::N_CH-1:0] tx_shift_amount,
  // Error block and ratio counters
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_err_state_entry,
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_clear_errblock_counter,
  output logic      [rlps_pkg::ERRBLK_W*rlps_pkg::N_CH-1:0] rx_errblock_count,
  input  wire logic [rlps_pkg::N_CH-1:0]                   rx_clear_ber_counter,
  output logic      [rlps_pkg::BERCNT_W*rlps_pkg::N_CH-1:0] rx_ber_count,
  output logic      [rlps_pkg::N_CH-1:0]                   rx_high_error_ratio,
  // Pattern verifier
  input  wire logic [rlps_pkg::N_CH-1:0]                   prbs_word_valid,
  input  wire logic [rlps_pkg::PRBS_W*rlps_pkg::N_CH-1:0]  prbs_word,
  input  wire logic [rlps_pkg::N_CH-1:0]                   prbs_verify_clear,
  output logic      [rlps_pkg::N_CH-1:0]                   prbs_verify_done,
  output logic      [rlps_pkg::N_CH-1:0]                   prbs_verify_error
);
  import rlps_pkg::*;

  localparam logic [BER_TMR_W-1:0] BER_WIN_LAST  = BER_TMR_W'(BER_WIN_CYC - 1);
  localparam logic [BER_TMR_W-1:0] BER_HOLD_LAST = BER_TMR_W'(BER_HOLD_CYC - 1);

  rlps_lock_e         lock_st   [N_CH];
  logic [6:0]         good_cnt  [N_CH];
  logic [5:0]         win_cnt   [N_CH];
  logic [4:0]         bad_cnt   [N_CH];
  logic [N_CH-1:0]    lockloss_ev;
  logic [N_CH-1:0]    sh_err_ev;
  logic [N_CH-1:0]    slip_prev;
  logic [BER_TMR_W-1:0] ber_tmr;
  logic [4:0]         ber_bad   [N_CH];
  logic [BER_TMR_W-1:0] ber_age [N_CH];
  logic [N_CH-1:0]    ber_rise_ev;
  logic [6:0]         prbs_seed [N_CH];
  logic [PRBS_W-1:0]  prbs_pred [N_CH];
  logic [4:0]         prbs_cnt  [N_CH];
  logic [N_CH-1:0]    prbs_aligned;
  logic [EV_W-1:0]    irq_status;
  logic [EV_W-1:0]    irq_mask;
  logic [EV_W-1:0]    events;
  logic [EV_W-1:0]    w1c;

  // ****************************************
  // Block lock
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int c = 0; c < N_CH; c++) begin
        lock_st[c]  <= LK_HUNT;
        good_cnt[c] <= 7'h00;
        win_cnt[c]  <= 6'h00;
        bad_cnt[c]  <= 5'h00;
      end
      rx_block_locked <= '0;
      lockloss_ev     <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        lockloss_ev[c] <= 1'b0;
        if (rx_hdr_valid[c]) begin
          unique case (lock_st[c])
            LK_HUNT: begin
              if (rx_hdr_bad[c]) begin
                good_cnt[c] <= 7'h00;
              end else if (good_cnt[c] == LOCK_GOOD_LAST) begin
                lock_st[c]         <= LK_LOCKED;
                rx_block_locked[c] <= 1'b1;
                good_cnt[c]        <= 7'h00;
                win_cnt[c]         <= 6'h00;
                bad_cnt[c]         <= 5'h00;
              end else begin
                good_cnt[c] <= good_cnt[c] + 7'h01;
              end
            end
            LK_LOCKED: begin
              // Sixteenth bad header inside one window drops lock
              if (rx_hdr_bad[c] && bad_cnt[c] == UNLOCK_BAD_LAST) begin
                lock_st[c]         <= LK_HUNT;
                rx_block_locked[c] <= 1'b0;
                lockloss_ev[c]     <= 1'b1;
              end else if (win_cnt[c] == MON_WIN_LAST) begin
                win_cnt[c] <= 6'h00;
                bad_cnt[c] <= rx_hdr_bad[c] ? 5'h01 : 5'h00;
              end else begin
                win_cnt[c] <= win_cnt[c] + 6'h01;
                if (rx_hdr_bad[c]) begin
                  bad_cnt[c] <= bad_cnt[c] + 5'h01;
                end
              end
            end
          endcase
        end
      end
    end
  end

  assign sh_err_ev = rx_hdr_valid & rx_hdr_bad & rx_block_locked;

  // Outputs cross to fabric; the user side must synchronize them
  rlps_stretch #(
    .W (N_CH)
  ) u_sh_stretch (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .ev        (sh_err_ev),
    .stretched (rx_bad_sync_header)
  );

  // ****************************************
  // Metaframe control words
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_skip_word_error <= '0;
      rx_diag_word_error <= '0;
      rx_lane_status_msg <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        // Flags freeze while unlocked
        if (rx_block_locked[c]) begin
          if (rx_skip_slot[c]) begin
            rx_skip_word_error[c] <= !rx_ctl_word_ok[c];
          end
          if (rx_diag_slot[c]) begin
            rx_diag_word_error[c] <= !rx_ctl_word_ok[c];
          end
        end
        if (rx_diag_slot[c] && rx_ctl_word_ok[c]) begin
          rx_lane_status_msg[2*c +: 2] <= rx_diag_lane_bits[2*c +: 2];
        end
      end
    end
  end

  // ****************************************
  // Gearbox slip
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      slip_prev      <= '0;
      rx_slip_offset <= '0;
    end else begin
      slip_prev <= rx_gearbox_slip;
      for (int c = 0; c < N_CH; c++) begin
        // Offset wraps modulo the gearbox width
        if (rx_gearbox_slip[c] && !slip_prev[c]) begin
          rx_slip_offset[RX_SLIP_W*c +: RX_SLIP_W] <=
            rx_slip_offset[RX_SLIP_W*c +: RX_SLIP_W] + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_shift_amount <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (tx_gearbox_shift[TX_SHIFT_W*c +: TX_SHIFT_W] > TX_SHIFT_MAX) begin
          tx_shift_amount[TX_SHIFT_W*c +: TX_SHIFT_W] <= TX_SHIFT_MAX;
        end else begin
          tx_shift_amount[TX_SHIFT_W*c +: TX_SHIFT_W] <=
            tx_gearbox_shift[TX_SHIFT_W*c +: TX_SHIFT_W];
        end
      end
    end
  end

  // ****************************************
  // Error block and bad header counters
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_errblock_count <= '0;
      rx_ber_count      <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        // A clear in the cycle of an entry keeps that entry
        if (rx_clear_errblock_counter[c]) begin
          rx_errblock_count[ERRBLK_W*c +: ERRBLK_W] <= {7'h00, rx_err_state_entry[c]};
        end else if (rx_err_state_entry[c] && !(&rx_errblock_count[ERRBLK_W*c +: ERRBLK_W])) begin
          rx_errblock_count[ERRBLK_W*c +: ERRBLK_W] <=
            rx_errblock_count[ERRBLK_W*c +: ERRBLK_W] + 8'h01;
        end
        if (rx_clear_ber_counter[c]) begin
          rx_ber_count[BERCNT_W*c +: BERCNT_W] <= {5'h00, sh_err_ev[c]};
        end else if (sh_err_ev[c] && !(&rx_ber_count[BERCNT_W*c +: BERCNT_W])) begin
          rx_ber_count[BERCNT_W*c +: BERCNT_W] <= rx_ber_count[BERCNT_W*c +: BERCNT_W] + 6'h01;
        end
      end
    end
  end

  // ****************************************
  // High error ratio monitor
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ber_tmr <= '0;
    end else if (ber_tmr == BER_WIN_LAST) begin
      ber_tmr <= '0;
    end else begin
      ber_tmr <= ber_tmr + 15'h0001;
    end
  end

  // Independent of the ratio counter clear, which only touches rx_ber_count
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int c = 0; c < N_CH; c++) begin
        ber_bad[c] <= 5'h00;
        ber_age[c] <= '0;
      end
      rx_high_error_ratio <= '0;
      ber_rise_ev         <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        ber_rise_ev[c] <= 1'b0;
        if (ber_tmr == BER_WIN_LAST) begin
          ber_bad[c] <= sh_err_ev[c] ? 5'h01 : 5'h00;
          // Drop only after a quiet window and a full hold time
          if (rx_high_error_ratio[c] && ber_bad[c] != HIGH_BER_BAD && ber_age[c] == BER_HOLD_LAST) begin
            rx_high_error_ratio[c] <= 1'b0;
          end
        end else if (sh_err_ev[c] && ber_bad[c] != HIGH_BER_BAD) begin
          ber_bad[c] <= ber_bad[c] + 5'h01;
          if (ber_bad[c] == HIGH_BER_BAD - 5'h01) begin
            rx_high_error_ratio[c] <= 1'b1;
            ber_rise_ev[c]         <= !rx_high_error_ratio[c];
            ber_age[c]             <= '0;
          end
        end
        if (rx_high_error_ratio[c] && ber_age[c] != BER_HOLD_LAST &&
            !(sh_err_ev[c] && ber_bad[c] == HIGH_BER_BAD - 5'h01)) begin
          ber_age[c] <= ber_age[c] + 15'h0001;
        end
      end
    end
  end

  // ****************************************
  // Pattern verifier
  // ****************************************
  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      prbs_pred[c] = rlps_prbs_next(prbs_seed[c]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int c = 0; c < N_CH; c++) begin
        prbs_seed[c] <= 7'h00;
        prbs_cnt[c]  <= 5'h00;
      end
      prbs_aligned      <= '0;
      prbs_verify_done  <= '0;
      prbs_verify_error <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        prbs_verify_error[c] <= 1'b0;
        if (prbs_verify_clear[c]) begin
          prbs_seed[c]        <= 7'h00;
          prbs_cnt[c]         <= 5'h00;
          prbs_aligned[c]     <= 1'b0;
          prbs_verify_done[c] <= 1'b0;
        end else if (prbs_word_valid[c]) begin
          if (!prbs_aligned[c]) begin
            prbs_seed[c]    <= prbs_word[PRBS_W*c +: 7];
            prbs_aligned[c] <= 1'b1;
            prbs_cnt[c]     <= 5'h00;
          end else if (!prbs_verify_done[c]) begin
            // Mismatch before done restarts alignment from this word
            prbs_seed[c] <= prbs_word[PRBS_W*c +: 7];
            if (prbs_word[PRBS_W*c +: PRBS_W] != prbs_pred[c]) begin
              prbs_cnt[c] <= 5'h00;
            end else if (prbs_cnt[c] == PRBS_PASS_LAST) begin
              prbs_verify_done[c] <= 1'b1;
            end else begin
              prbs_cnt[c] <= prbs_cnt[c] + 5'h01;
            end
          end else begin
            // Free-run on the prediction so one bad word gives one pulse
            prbs_seed[c]         <= prbs_pred[c][6:0];
            prbs_verify_error[c] <= prbs_word[PRBS_W*c +: PRBS_W] != prbs_pred[c];
          end
        end
      end
    end
  end

  // ****************************************
  // Interrupts and register port
  // ****************************************
  assign events = {prbs_verify_error, ber_rise_ev, lockloss_ev};
  assign w1c    = (reg_wr && reg_addr == REG_IRQ_STATUS) ? reg_wdata[EV_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      // Set wins over a same-cycle clear
      irq_status <= (irq_status & ~w1c) | events;
      irq        <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (reg_wr && reg_addr == REG_IRQ_MASK) begin
      irq_mask <= reg_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_IRQ_STATUS: reg_rdata <= {20'h00000, irq_status};
        REG_IRQ_MASK:   reg_rdata <= {20'h00000, irq_mask};
        REG_LIVE:       reg_rdata <= {20'h00000, prbs_verify_done, rx_high_error_ratio, rx_block_locked};
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : rlps_top

// [bench/rlps_top_sva.sv]
`timescale 1ns/1ns
module rlps_top_sva
  import rlps_pkg::*;
#(
  parameter int BER_HOLD_CYC = 64
) (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_b,
  // Block synchronizer and ratio monitor
  input wire logic [N_CH-1:0]            rx_hdr_valid,
  input wire logic [N_CH-1:0]            rx_hdr_bad,
  input wire logic [N_CH-1:0]            rx_block_locked,
  input wire logic [N_CH-1:0]            rx_bad_sync_header,
  input wire logic [N_CH-1:0]            rx_high_error_ratio,
  input wire logic [N_CH-1:0]            rx_clear_ber_counter,
  input wire logic [BERCNT_W*N_CH-1:0]   rx_ber_count,
  // Gearbox
  input wire logic [N_CH-1:0]            rx_gearbox_slip,
  input wire logic [RX_SLIP_W*N_CH-1:0]  rx_slip_offset,
  input wire logic [TX_SHIFT_W*N_CH-1:0] tx_gearbox_shift,
  input wire logic [TX_SHIFT_W*N_CH-1:0] tx_shift_amount,
  // Error blocks and verifier
  input wire logic [N_CH-1:0]            rx_err_state_entry,
  input wire logic [N_CH-1:0]            rx_clear_errblock_counter,
  input wire logic [ERRBLK_W*N_CH-1:0]   rx_errblock_count,
  input wire logic [N_CH-1:0]            prbs_verify_done,
  input wire logic [N_CH-1:0]            prbs_verify_error
);
  int hi_cnt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Cycles ratio flag high, saturating
  always_ff @(posedge core_clk) begin
    if (!rst_b || !rx_high_error_ratio[0]) hi_cnt <= 0;
    else if (hi_cnt < BER_HOLD_CYC) hi_cnt <= hi_cnt + 1;
  end

  hdr_stretch_a : assert property (
    rx_hdr_valid[0] && rx_hdr_bad[0] && rx_block_locked[0] |=> rx_bad_sync_header[0] [*3])
    else $error("stretch short");
  hdr_quiet_a : assert property (
    $rose(rx_bad_sync_header[0]) |-> $past(rx_block_locked[0]))
    else $error("flag unlocked");
  slip_step_a : assert property (
    $rose(rx_gearbox_slip[0]) |=> rx_slip_offset[5:0] == $past(rx_slip_offset[5:0]) + 6'h01)
    else $error("slip step");
  shift_clamp_a : assert property (
    $past(rst_b) |-> tx_shift_amount[6:0] == (($past(tx_gearbox_shift[6:0]) > TX_SHIFT_MAX) ?
                     TX_SHIFT_MAX : $past(tx_gearbox_shift[6:0])))
    else $error("shift clamp");
  errblk_clear_a : assert property (
    rx_clear_errblock_counter[0] && !rx_err_state_entry[0] |=> rx_errblock_count[7:0] == 8'h00)
    else $error("errblk clear");
  ber_clear_a : assert property (
    rx_clear_ber_counter[0] && !(rx_hdr_valid[0] && rx_hdr_bad[0]) |=> rx_ber_count[5:0] == 6'h00)
    else $error("ber clear");
  ratio_hold_a : assert property (
    $fell(rx_high_error_ratio[0]) |-> hi_cnt >= BER_HOLD_CYC)
    else $error("ratio early drop");
  prbs_after_done_a : assert property (
    prbs_verify_error[0] |-> $past(prbs_verify_done[0]))
    else $error("error before done");
endmodule : rlps_top_sva

// [bench/rlps_fabric.sv]
`timescale 1ns/1ns
module rlps_fabric
  import rlps_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  // Stretched status
  input  wire logic [N_CH-1:0] rx_bad_sync_header,
  // Core clock view
  output logic      [N_CH-1:0] bad_hdr_sync,
  output int                   bad_hdr_events
);
  logic [N_CH-1:0] meta;

  // Untimed to core clock: two flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      meta         <= '0;
      bad_hdr_sync <= '0;
    end else begin
      meta         <= rx_bad_sync_header;
      bad_hdr_sync <= meta;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) bad_hdr_events <= 0;
    else if (meta[0] && !bad_hdr_sync[0]) bad_hdr_events <= bad_hdr_events + 1;
  end
endmodule : rlps_fabric

// [bench/tb.sv]
`timescale 1ns/1ns
module tb;
  import rlps_pkg::*;
  localparam int WIN = 256;
  typedef struct {string nm; logic [DATA_W-1:0] v;} rlps_note_s;
  logic core_clk, rst_b, reg_wr, reg_rd, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, got;
  logic [N_CH-1:0] rx_hdr_valid, rx_hdr_bad, rx_block_locked, rx_bad_sync_header, rx_skip_slot, rx_diag_slot;
  logic [N_CH-1:0] rx_ctl_word_ok, rx_skip_word_error, rx_diag_word_error, rx_gearbox_slip, rx_err_state_entry;
  logic [N_CH-1:0] rx_clear_errblock_counter, rx_clear_ber_counter, rx_high_error_ratio, bad_hdr_sync;
  logic [N_CH-1:0] prbs_word_valid, prbs_verify_clear, prbs_verify_done, prbs_verify_error;
  logic [2*N_CH-1:0] rx_diag_lane_bits, rx_lane_status_msg, lane, msg_exp;
  logic [RX_SLIP_W*N_CH-1:0] rx_slip_offset;
  logic [TX_SHIFT_W*N_CH-1:0] tx_gearbox_shift, tx_shift_amount, shift_v, tx_exp;
  logic [ERRBLK_W*N_CH-1:0] rx_errblock_count;
  logic [BERCNT_W*N_CH-1:0] rx_ber_count;
  logic [PRBS_W*N_CH-1:0] prbs_word;
  logic [PRBS_W-1:0] pw;
  logic [6:0] lfsr;
  int seed = 24;
  int err_count = 0;
  int total_checks = 0;
  int bad_hdr_events, n;
  rlps_note_s exp_q[$];
  rlps_note_s note;

  // Short ratio window and hold
  rlps_top #(.BER_WIN_CYC(WIN), .BER_HOLD_CYC(WIN)) i_rlps_top (.*);
  rlps_fabric i_rlps_fabric (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ********
  // Drivers
  // ********
  task automatic tick(input int k = 1);
    repeat (k) @(posedge core_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [DATA_W-1:0] v);
    exp_q.push_back('{nm, v});
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    chk("reg_rdata", e);
    reg_rd <= 1'b0;
    tick();
  endtask : rd
  task automatic hdrs(input int k, input logic [N_CH-1:0] bad);
    rx_hdr_valid <= '1;
    rx_hdr_bad <= bad;
    tick(k);
  endtask : hdrs
  task automatic hdr_stop;
    rx_hdr_valid <= '0;
    tick();
  endtask : hdr_stop
  task automatic ctl(input logic skip, input logic ok);
    lane = $random(seed);
    rx_skip_slot <= {N_CH{skip}};
    rx_diag_slot <= {N_CH{!skip}};
    rx_ctl_word_ok <= {N_CH{ok}};
    rx_diag_lane_bits <= lane;
    tick();
    rx_skip_slot <= '0;
    rx_diag_slot <= '0;
    tick();
  endtask : ctl
  function automatic logic [PRBS_W-1:0] lfsr_word();
    for (int i = PRBS_W - 1; i >= 0; i--) begin
      pw[i] = lfsr[6] ^ lfsr[5];
      lfsr = {lfsr[5:0], pw[i]};
    end
    return pw;
  endfunction : lfsr_word
  task automatic words(input int k, input logic [PRBS_W-1:0] flip, input logic [N_CH-1:0] e = '0);
    repeat (k) begin
      prbs_word <= {N_CH{lfsr_word() ^ flip}};
      prbs_word_valid <= '1;
      tick();
      chk("prbs_verify_error", 32'(e));
    end
    prbs_word_valid <= '0;
    tick();
  endtask : words

  // ********
  // Monitor and verdict
  // ********
  always @(negedge core_clk) begin
    while (exp_q.size() > 0) begin
      note = exp_q.pop_front();
      case (note.nm)
        "reg_rdata": got = reg_rdata;
        "irq": got = 32'(irq);
        "rx_block_locked": got = 32'(rx_block_locked);
        "rx_bad_sync_header": got = 32'(rx_bad_sync_header);
        "rx_skip_word_error": got = 32'(rx_skip_word_error);
        "rx_diag_word_error": got = 32'(rx_diag_word_error);
        "rx_lane_status_msg": got = 32'(rx_lane_status_msg);
        "rx_slip_offset": got = 32'(rx_slip_offset);
        "tx_shift_amount": got = 32'(tx_shift_amount);
        "rx_errblock_count": got = rx_errblock_count;
        "rx_ber_count": got = 32'(rx_ber_count);
        "rx_high_error_ratio": got = 32'(rx_high_error_ratio);
        "prbs_verify_done": got = 32'(prbs_verify_done);
        "prbs_verify_error": got = 32'(prbs_verify_error);
        default: got = 32'(bad_hdr_events);
      endcase
      total_checks++;
      if (got !== note.v) begin
        err_count++;
        $display("Error: %s expected %h seen %h", note.nm, note.v, got);
      end
    end
  end

  task automatic end_sim;
    @(negedge core_clk);
    #1;
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial begin
    tick(20000);
    err_count++;
    end_sim();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, rx_hdr_valid, rx_hdr_bad, rx_skip_slot, rx_diag_slot, rx_ctl_word_ok,
     rx_diag_lane_bits, rx_gearbox_slip, tx_gearbox_shift, rx_err_state_entry, rx_clear_errblock_counter,
     rx_clear_ber_counter, prbs_word_valid, prbs_word, prbs_verify_clear} <= '0;
    rst_b <= 1'b0;
    tick(5);
    rst_b <= 1'b1;
    tick();
    rd(REG_IRQ_STATUS, 32'h0);
    rd(REG_IRQ_MASK, 32'h0);
    wr(8'h0c, '1);
    rd(8'h0c, 32'h0);
    hdrs(8, '1);
    hdr_stop();
    chk("rx_ber_count", 32'h0);
    hdrs(63, '0);
    chk("rx_block_locked", 32'h0);
    hdrs(1, '0);
    chk("rx_block_locked", 32'hf);
    hdr_stop();
    ctl(1'b1, 1'b0);
    chk("rx_skip_word_error", 32'hf);
    ctl(1'b0, 1'b1);
    msg_exp = lane;
    chk("rx_lane_status_msg", 32'(msg_exp));
    ctl(1'b0, 1'b0);
    chk("rx_diag_word_error", 32'hf);
    chk("rx_lane_status_msg", 32'(msg_exp));
    // 4 bad per 64: lock holds, window sees 16
    repeat (12) begin
      hdrs(4, '1);
      hdrs(60, '0);
    end
    hdr_stop();
    chk("rx_high_error_ratio", 32'hf);
    chk("rx_ber_count", {8'h0, {N_CH{6'd48}}});
    chk("bad_hdr_events", 32'd12);
    rx_clear_ber_counter <= '1;
    tick();
    rx_clear_ber_counter <= '0;
    tick();
    chk("rx_ber_count", 32'h0);
    chk("rx_high_error_ratio", 32'hf);
    rd(REG_IRQ_STATUS, 32'h0f0);
    wr(REG_IRQ_MASK, 32'h0f0);
    chk("irq", 32'h1);
    wr(REG_IRQ_STATUS, 32'h0f0);
    chk("irq", 32'h0);
    tick(3 * WIN);
    chk("rx_high_error_ratio", 32'h0);
    n = 1 + ($unsigned($random(seed)) % 8);
    repeat (n) begin
      rx_gearbox_slip <= '1;
      tick(3);
      rx_gearbox_slip <= '0;
      tick();
    end
    chk("rx_slip_offset", 32'({N_CH{6'(n)}}));
    for (int i = 0; i < 6; i++) begin
      shift_v = (i == 0) ? {7'h7f, 7'h40, 7'h3f, 7'h00} : (TX_SHIFT_W*N_CH)'($random(seed));
      tx_gearbox_shift <= shift_v;
      tick(2);
      for (int c = 0; c < N_CH; c++) begin
        tx_exp[7*c +: 7] = (shift_v[7*c +: 7] > 7'(GB_WIDTH - 1)) ? 7'(GB_WIDTH - 1) : shift_v[7*c +: 7];
      end
      chk("tx_shift_amount", 32'(tx_exp));
    end
    n = 1 + ($unsigned($random(seed)) % 10);
    repeat (n) begin
      rx_err_state_entry <= '1;
      tick();
      rx_err_state_entry <= '0;
      tick();
    end
    chk("rx_errblock_count", {N_CH{8'(n)}});
    rx_clear_errblock_counter <= '1;
    rx_err_state_entry <= '1;
    tick();
    chk("rx_errblock_count", {N_CH{8'h01}});
    rx_err_state_entry <= '0;
    tick();
    rx_clear_errblock_counter <= '0;
    tick();
    chk("rx_errblock_count", 32'h0);
    lfsr = 7'h01 | 7'($random(seed));
    words(16, 8'h00);
    chk("prbs_verify_done", 32'h0);
    words(1, 8'h00);
    chk("prbs_verify_done", 32'hf);
    words(1, 8'h10, '1);
    chk("prbs_verify_error", 32'h0);
    words(1, 8'h00);
    chk("prbs_verify_error", 32'h0);
    wr(REG_LIVE, 32'h0);
    rd(REG_LIVE, 32'hf0f);
    rd(REG_IRQ_STATUS, 32'hf00);
    wr(REG_IRQ_STATUS, 32'hfff);
    prbs_verify_clear <= '1;
    tick();
    prbs_verify_clear <= '0;
    tick();
    chk("prbs_verify_done", 32'h0);
    words(4, 8'h01);
    chk("prbs_verify_error", 32'h0);
    ctl(1'b1, 1'b0);
    hdrs(64, '0);
    hdrs(15, '1);
    chk("rx_block_locked", 32'hf);
    hdrs(17, '1);
    hdr_stop();
    chk("rx_block_locked", 32'h0);
    wr(REG_IRQ_MASK, 32'h00f);
    chk("irq", 32'h1);
    ctl(1'b1, 1'b1);
    chk("rx_skip_word_error", 32'hf);
    ctl(1'b0, 1'b1);
    chk("rx_diag_word_error", 32'hf);
    hdrs(64, '0);
    hdr_stop();
    ctl(1'b1, 1'b1);
    chk("rx_skip_word_error", 32'h0);
    end_sim();
  end
endmodule : tb

bind rlps_top rlps_top_sva #(.BER_HOLD_CYC(BER_HOLD_CYC)) i_rlps_top_sva (.*);
